/* File: design/bgr_defines.svh */
// offsets, field positions, reset values and timing counts of the reset and interrupt block
`ifndef BGR_DEFINES_SVH
`define BGR_DEFINES_SVH

// device-side register indices on the link register port
`define BGR_DIDX_DEC1 3'h0
`define BGR_DIDX_MASK1 3'h1
`define BGR_DIDX_DEC2 3'h2
`define BGR_DIDX_MASK2 3'h3
`define BGR_DIDX_MSI_LO 3'h4
`define BGR_DIDX_MSI_HI 3'h5
`define BGR_DIDX_STATUS 3'h6
`define BGR_DEC2_W 4
`define BGR_MASK_RST 32'h00000000

// host-side apb register byte offsets
`define BGR_HOFF_CTRL 12'h000
`define BGR_HOFF_STATUS 12'h004
`define BGR_HOFF_MSI_EVT 12'h008
`define BGR_HOFF_INTX_EVT 12'h00c
`define BGR_HOFF_GEN_EVT 12'h010
`define BGR_HOFF_DEV_BASE 4'h1
`define BGR_CTRL_RST 6'h01

// ctrl field positions
`define BGR_CTRL_SOFT_RUN 0
`define BGR_CTRL_SYS_RUN 1
`define BGR_CTRL_CORE_RST 2
`define BGR_CTRL_PHY_RDY 3
`define BGR_CTRL_LINK_UP 4
`define BGR_CTRL_PWR_ACT 5
`define BGR_INTX_ASSERT_BIT 2

// timing
`define BGR_CLK_PERIOD_NS 50
`define BGR_SOFT_MIN_NS 50000000
`define BGR_SOFT_HOLD_CYC (`BGR_SOFT_MIN_NS / `BGR_CLK_PERIOD_NS + 1)
`define BGR_SOFT_CNT_W 24

`endif

/* File: design/bgr_pkg.sv */
// types shared by both ends of the reset and interrupt block
package bgr_pkg;
`include "bgr_defines.svh"

	typedef enum logic [1:0] {
		BGR_H_IDLE = 2'b01,
		BGR_H_WAIT = 2'b10
	} bgr_hstate_type;

	typedef struct packed {
		logic [31:0] dec1;
		logic [31:0] mask1;
		logic [`BGR_DEC2_W-1:0] dec2;
		logic [31:0] mask2;
		logic [31:0] msi_lo;
		logic [31:0] msi_hi;
		logic bus_rst_n;
		logic ctl_rst_n;
		logic irq;
		logic msi_lo_irq;
		logic msi_hi_irq;
		logic ack;
		logic [31:0] rdata;
	} bgr_dev_state_type;

	typedef struct packed {
		logic [5:0] ctrl;
		logic [`BGR_SOFT_CNT_W-1:0] hold_cnt;
		logic soft_n;
		bgr_hstate_type st;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic req;
		logic req_wr;
		logic [2:0] req_idx;
		logic [31:0] req_wdata;
		logic msi_v;
		logic [5:0] msi_vec;
		logic intx_v;
		logic intx_as;
		logic [1:0] intx_line;
		logic gen_v;
		logic [4:0] gen_bit;
	} bgr_host_state_type;
endpackage

/* File: design/bgr_link_if.sv */
// link between the bridge reset/interrupt logic and the pcie block plus user logic
`timescale 1ns/1ps
interface bgr_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic core_user_reset_in;
	logic phy_ready_in;
	logic link_up_in;
	logic power_state_active;
	logic soft_reset_n;
	logic sys_rst_n;
	logic msi_evt_valid;
	logic [5:0] msi_evt_vec;
	logic intx_evt_valid;
	logic intx_evt_assert;
	logic [1:0] intx_evt_line;
	logic gen_evt_valid;
	logic [4:0] gen_evt_bit;
	logic reg_req;
	logic reg_wr;
	logic [2:0] reg_idx;
	logic [31:0] reg_wdata;
	logic reg_ack;
	logic [31:0] reg_rdata;
	logic bus_reset_n;
	logic ctl_reset_n;
	logic irq_line;
	logic msi_low_irq_line;
	logic msi_high_irq_line;

	modport dev (
		input pclk, presetn, core_user_reset_in, phy_ready_in, link_up_in,
		input power_state_active, soft_reset_n, sys_rst_n,
		input msi_evt_valid, msi_evt_vec, intx_evt_valid, intx_evt_assert, intx_evt_line,
		input gen_evt_valid, gen_evt_bit, reg_req, reg_wr, reg_idx, reg_wdata,
		output reg_ack, reg_rdata, bus_reset_n, ctl_reset_n,
		output irq_line, msi_low_irq_line, msi_high_irq_line
	);
	modport host (
		input pclk, presetn,
		output core_user_reset_in, phy_ready_in, link_up_in,
		output power_state_active, soft_reset_n, sys_rst_n,
		output msi_evt_valid, msi_evt_vec, intx_evt_valid, intx_evt_assert, intx_evt_line,
		output gen_evt_valid, gen_evt_bit, reg_req, reg_wr, reg_idx, reg_wdata,
		input reg_ack, reg_rdata, bus_reset_n, ctl_reset_n,
		input irq_line, msi_low_irq_line, msi_high_irq_line
	);
endinterface

/* File: design/bgr_irq_reduce.sv */
// one decode/mask pair reduced to a single pending level
`timescale 1ns/1ps
module bgr_irq_reduce #(
	parameter int W = 32
) (
	input wire logic [W-1:0] decode,
	input wire logic [W-1:0] mask,
	output logic hit
);
	// a mask bit of one blocks its decode bit
	assign hit = |(decode & ~mask);
endmodule

/* File: design/bgr_device.sv */
// bridge global reset release and interrupt line logic, device end of the link
// Function
// - endpoint: bus reset held until power active
// - root port: bus reset released on phy ready
// - endpoint: control reset held until power active
// - root port: control reset released on phy ready
// - bus clock may stop during reset
// - general irq: either decode/mask pair pending
// - low msi line: low decode unmasked by mask1
// - high msi line: high decode unmasked by mask2
// - msi lines only in root decode mode
// - quiesce traffic before soft reset
// - soft reset held longer than 50 ms
// - soft reset clears engines, asserts both resets
// - soft reset not needed at link-up
// - all logic on the core user clock
// - core user reset is active high
// - phy ready is active high
// - link up is active high
// - software clears msi bit by writing one
// - intx deassert message clears decode bit
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "bgr_defines.svh"
module bgr_device
	import bgr_pkg::*;
#(
	parameter bit ROOT_PORT = 1'b1,
	parameter bit IRQ_DECODE_MODE = 1'b1
) (
	bgr_link_if.dev link,
	output logic bus_reset_n,
	output logic ctl_reset_n,
	output logic irq_line,
	output logic msi_low_irq_line,
	output logic msi_high_irq_line
);
	import bgr_pkg::*;

	localparam int NPAIR = 4;

	bgr_dev_state_type s_r;
	bgr_dev_state_type s_nxt;
	logic [31:0] pair_dec [NPAIR];
	logic [31:0] pair_mask [NPAIR];
	logic [NPAIR-1:0] pair_hit;
	logic eng_rst;
	logic ready_cond;
	logic [31:0] wr_ones [7];
	logic [31:0] rd_mux;

	function automatic logic [31:0] bit_of(input logic [4:0] pos);
		logic [31:0] v;
		v = 32'h00000000;
		v[pos] = 1'b1;
		return v;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// pending levels per pair

	assign pair_dec[0] = s_r.dec1;
	assign pair_mask[0] = s_r.mask1;
	assign pair_dec[1] = {{(32-`BGR_DEC2_W){1'b0}}, s_r.dec2};
	assign pair_mask[1] = s_r.mask2;
	assign pair_dec[2] = s_r.msi_lo;
	assign pair_mask[2] = s_r.mask1;
	assign pair_dec[3] = s_r.msi_hi;
	assign pair_mask[3] = s_r.mask2;

	generate
		for (genvar g = 0; g < NPAIR; g++) begin : g_pair
			bgr_irq_reduce #(.W(32)) u_red (
				.decode(pair_dec[g]),
				.mask(pair_mask[g]),
				.hit(pair_hit[g])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// reset conditions

	assign eng_rst = link.core_user_reset_in | ~link.soft_reset_n | ~link.sys_rst_n;
	assign ready_cond = ROOT_PORT ? link.phy_ready_in : link.power_state_active;

	always_comb begin
		for (int i = 0; i < 7; i++) begin
			wr_ones[i] = (link.reg_req && link.reg_wr && link.reg_idx == 3'(i)) ?
				link.reg_wdata : 32'h00000000;
		end
		rd_mux = 32'h00000000;
		if (link.reg_idx == `BGR_DIDX_DEC1) begin
			rd_mux = s_r.dec1;
		end else if (link.reg_idx == `BGR_DIDX_MASK1) begin
			rd_mux = s_r.mask1;
		end else if (link.reg_idx == `BGR_DIDX_DEC2) begin
			rd_mux = pair_dec[1];
		end else if (link.reg_idx == `BGR_DIDX_MASK2) begin
			rd_mux = s_r.mask2;
		end else if (link.reg_idx == `BGR_DIDX_MSI_LO) begin
			rd_mux = s_r.msi_lo;
		end else if (link.reg_idx == `BGR_DIDX_MSI_HI) begin
			rd_mux = s_r.msi_hi;
		end else if (link.reg_idx == `BGR_DIDX_STATUS) begin
			rd_mux = {27'h0000000, link.power_state_active, link.link_up_in,
				link.phy_ready_in, s_r.ctl_rst_n, s_r.bus_rst_n};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] msi_set;
		logic [`BGR_DEC2_W-1:0] intx_set;
		logic [`BGR_DEC2_W-1:0] intx_clr;
		msi_set = link.msi_evt_valid ? bit_of(link.msi_evt_vec[4:0]) : 32'h00000000;
		intx_set = 4'h0;
		intx_clr = 4'h0;
		if (link.intx_evt_valid) begin
			if (link.intx_evt_assert) begin
				intx_set[link.intx_evt_line] = 1'b1;
			end else begin
				intx_clr[link.intx_evt_line] = 1'b1;
			end
		end
		s_nxt = s_r;
		s_nxt.ack = link.reg_req;
		s_nxt.rdata = link.reg_req ? rd_mux : s_r.rdata;
		s_nxt.mask1 = wr_ones[`BGR_DIDX_MASK1] | (s_r.mask1 &
			~((link.reg_req && link.reg_wr && link.reg_idx == `BGR_DIDX_MASK1) ?
			32'hffffffff : 32'h00000000));
		s_nxt.mask2 = (link.reg_req && link.reg_wr && link.reg_idx == `BGR_DIDX_MASK2) ?
			link.reg_wdata : s_r.mask2;
		// new events win over a write-one clear in the same cycle
		s_nxt.dec1 = (s_r.dec1 & ~wr_ones[`BGR_DIDX_DEC1]) |
			(link.gen_evt_valid ? bit_of(link.gen_evt_bit) : 32'h00000000);
		s_nxt.dec2 = ((s_r.dec2 & ~wr_ones[`BGR_DIDX_DEC2][`BGR_DEC2_W-1:0]) & ~intx_clr) |
			intx_set;
		s_nxt.msi_lo = (s_r.msi_lo & ~wr_ones[`BGR_DIDX_MSI_LO]) |
			(link.msi_evt_vec[5] ? 32'h00000000 : msi_set);
		s_nxt.msi_hi = (s_r.msi_hi & ~wr_ones[`BGR_DIDX_MSI_HI]) |
			(link.msi_evt_vec[5] ? msi_set : 32'h00000000);
		s_nxt.bus_rst_n = ~eng_rst & ready_cond;
		s_nxt.ctl_rst_n = ~eng_rst & ready_cond;
		s_nxt.irq = pair_hit[0] | pair_hit[1];
		s_nxt.msi_lo_irq = ROOT_PORT && IRQ_DECODE_MODE && pair_hit[2];
		s_nxt.msi_hi_irq = ROOT_PORT && IRQ_DECODE_MODE && pair_hit[3];
		if (eng_rst) begin
			s_nxt.dec1 = 32'h00000000;
			s_nxt.mask1 = `BGR_MASK_RST;
			s_nxt.dec2 = 4'h0;
			s_nxt.mask2 = `BGR_MASK_RST;
			s_nxt.msi_lo = 32'h00000000;
			s_nxt.msi_hi = 32'h00000000;
			s_nxt.irq = 1'b0;
			s_nxt.msi_lo_irq = 1'b0;
			s_nxt.msi_hi_irq = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// state register

	// logic assumes no clock during reset beyond this edge
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.reg_ack = s_r.ack;
	assign link.reg_rdata = s_r.rdata;
	assign link.bus_reset_n = s_r.bus_rst_n;
	assign link.ctl_reset_n = s_r.ctl_rst_n;
	assign link.irq_line = s_r.irq;
	assign link.msi_low_irq_line = s_r.msi_lo_irq;
	assign link.msi_high_irq_line = s_r.msi_hi_irq;
	assign bus_reset_n = s_r.bus_rst_n;
	assign ctl_reset_n = s_r.ctl_rst_n;
	assign irq_line = s_r.irq;
	assign msi_low_irq_line = s_r.msi_lo_irq;
	assign msi_high_irq_line = s_r.msi_hi_irq;
endmodule

/* File: design/bgr_host.sv */
// pcie block and user logic end: apb registers that drive the link
`timescale 1ns/1ps
`include "bgr_defines.svh"
module bgr_host
	import bgr_pkg::*;
#(
	parameter int SOFT_HOLD_CYC = `BGR_SOFT_HOLD_CYC
) (
	bgr_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import bgr_pkg::*;

	bgr_host_state_type s_r;
	bgr_host_state_type s_nxt;
	logic setup;
	logic commit;
	logic dev_hit;
	logic [31:0] loc_rd;
	logic loc_ok;

	assign setup = psel && !penable && s_r.st == BGR_H_IDLE && !s_r.pready;
	assign commit = psel && penable && s_r.pready;
	assign dev_hit = paddr[11:8] == `BGR_HOFF_DEV_BASE && paddr[4:2] != 3'h7;

	always_comb begin
		loc_ok = 1'b1;
		loc_rd = 32'h00000000;
		if (paddr == `BGR_HOFF_CTRL) begin
			loc_rd = {26'h0000000, s_r.ctrl};
		end else if (paddr == `BGR_HOFF_STATUS) begin
			loc_rd = {25'h0000000, s_r.hold_cnt != '0, s_r.soft_n, link.msi_high_irq_line,
				link.msi_low_irq_line, link.irq_line, link.ctl_reset_n, link.bus_reset_n};
		end else if (paddr == `BGR_HOFF_MSI_EVT || paddr == `BGR_HOFF_INTX_EVT ||
			paddr == `BGR_HOFF_GEN_EVT) begin
			loc_rd = 32'h00000000;
		end else begin
			loc_ok = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.req = 1'b0;
		s_nxt.msi_v = 1'b0;
		s_nxt.intx_v = 1'b0;
		s_nxt.gen_v = 1'b0;
		if (s_r.hold_cnt != '0) begin
			s_nxt.hold_cnt = s_r.hold_cnt - 1'b1;
		end
		case (s_r.st)
			BGR_H_IDLE: begin
				if (commit) begin
					s_nxt.pready = 1'b0;
					s_nxt.pslverr = 1'b0;
				end else if (setup && dev_hit) begin
					// device registers answer over the link one cycle later
					s_nxt.req = 1'b1;
					s_nxt.req_wr = pwrite;
					s_nxt.req_idx = paddr[4:2];
					s_nxt.req_wdata = pwdata;
					s_nxt.st = BGR_H_WAIT;
				end else if (setup) begin
					s_nxt.pready = 1'b1;
					s_nxt.pslverr = !loc_ok;
					s_nxt.prdata = pwrite ? 32'h00000000 : loc_rd;
				end
				if (commit && pwrite && loc_ok) begin
					if (paddr == `BGR_HOFF_CTRL) begin
						s_nxt.ctrl = pwdata[5:0];
						// soft reset only on software request
						// hold low past the completion timeout
						if (s_r.ctrl[`BGR_CTRL_SOFT_RUN] && !pwdata[`BGR_CTRL_SOFT_RUN]) begin
							s_nxt.hold_cnt = `BGR_SOFT_CNT_W'(SOFT_HOLD_CYC);
						end
					end else if (paddr == `BGR_HOFF_MSI_EVT) begin
						s_nxt.msi_v = 1'b1;
						s_nxt.msi_vec = pwdata[5:0];
					end else if (paddr == `BGR_HOFF_INTX_EVT) begin
						s_nxt.intx_v = 1'b1;
						s_nxt.intx_line = pwdata[1:0];
						s_nxt.intx_as = pwdata[`BGR_INTX_ASSERT_BIT];
					end else if (paddr == `BGR_HOFF_GEN_EVT) begin
						s_nxt.gen_v = 1'b1;
						s_nxt.gen_bit = pwdata[4:0];
					end
				end
			end
			BGR_H_WAIT: begin
				if (link.reg_ack) begin
					s_nxt.pready = 1'b1;
					s_nxt.pslverr = 1'b0;
					s_nxt.prdata = s_r.req_wr ? 32'h00000000 : link.reg_rdata;
					s_nxt.st = BGR_H_IDLE;
				end
			end
			default: begin
				s_nxt.st = BGR_H_IDLE;
			end
		endcase
		// apb serialises traffic, so no link access overlaps the soft reset request
		s_nxt.soft_n = s_nxt.ctrl[`BGR_CTRL_SOFT_RUN] && s_nxt.hold_cnt == '0;
	end

	//////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			s_r <= '0;
			s_r.ctrl <= `BGR_CTRL_RST;
			s_r.soft_n <= 1'b1;
			s_r.st <= BGR_H_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign link.soft_reset_n = s_r.soft_n;
	assign link.sys_rst_n = s_r.ctrl[`BGR_CTRL_SYS_RUN];
	assign link.core_user_reset_in = s_r.ctrl[`BGR_CTRL_CORE_RST];
	assign link.phy_ready_in = s_r.ctrl[`BGR_CTRL_PHY_RDY];
	assign link.link_up_in = s_r.ctrl[`BGR_CTRL_LINK_UP];
	assign link.power_state_active = s_r.ctrl[`BGR_CTRL_PWR_ACT];
	assign link.msi_evt_valid = s_r.msi_v;
	assign link.msi_evt_vec = s_r.msi_vec;
	assign link.intx_evt_valid = s_r.intx_v;
	assign link.intx_evt_assert = s_r.intx_as;
	assign link.intx_evt_line = s_r.intx_line;
	assign link.gen_evt_valid = s_r.gen_v;
	assign link.gen_evt_bit = s_r.gen_bit;
	assign link.reg_req = s_r.req;
	assign link.reg_wr = s_r.req_wr;
	assign link.reg_idx = s_r.req_idx;
	assign link.reg_wdata = s_r.req_wdata;
endmodule

/* File: tb/bgr_asserts.sv */
// concurrent checks on the link between the host end and the device end
`timescale 1ns/1ps
`include "bgr_defines.svh"
module bgr_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic core_user_reset_in,
	input wire logic phy_ready_in,
	input wire logic soft_reset_n,
	input wire logic sys_rst_n,
	input wire logic msi_evt_valid,
	input wire logic [5:0] msi_evt_vec,
	input wire logic intx_evt_valid,
	input wire logic intx_evt_assert,
	input wire logic [1:0] intx_evt_line,
	input wire logic gen_evt_valid,
	input wire logic [4:0] gen_evt_bit,
	input wire logic reg_req,
	input wire logic reg_wr,
	input wire logic [2:0] reg_idx,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic bus_reset_n,
	input wire logic ctl_reset_n,
	input wire logic irq_line,
	input wire logic msi_low_irq_line,
	input wire logic msi_high_irq_line
);
	logic eng;
	logic [31:0] m1_r;
	logic [31:0] m2_r;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign eng = core_user_reset_in | !soft_reset_n | !sys_rst_n;
	////////////////////////////////////////////////////////////////
	// mask shadow: a set is only expected to show when unmasked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m1_r <= 32'h00000000;
			m2_r <= 32'h00000000;
		end else if (eng) begin
			m1_r <= 32'h00000000;
			m2_r <= 32'h00000000;
		end else if (reg_req && reg_wr && reg_idx == `BGR_DIDX_MASK1) begin
			m1_r <= reg_wdata;
		end else if (reg_req && reg_wr && reg_idx == `BGR_DIDX_MASK2) begin
			m2_r <= reg_wdata;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_rel;
		!eng && phy_ready_in |=> bus_reset_n && ctl_reset_n;
	endproperty
	a_rel: assert property (p_rel) else $error("bus resets not released");
	property p_hold;
		eng || !phy_ready_in |=> !bus_reset_n && !ctl_reset_n;
	endproperty
	a_hold: assert property (p_hold) else $error("bus resets released early");
	property p_irq_clr;
		eng [*2] |=> !irq_line && !msi_low_irq_line && !msi_high_irq_line;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq kept in reset");
	property p_gen;
		(gen_evt_valid && !m1_r[gen_evt_bit] && !eng) ##1 !eng [*3] |-> irq_line;
	endproperty
	a_gen: assert property (p_gen) else $error("general irq missing");
	property p_intx;
		(intx_evt_valid && intx_evt_assert && !m2_r[intx_evt_line] && !eng)
			##1 !eng [*3] |-> irq_line;
	endproperty
	a_intx: assert property (p_intx) else $error("intx irq missing");
	property p_msi_lo;
		(msi_evt_valid && !msi_evt_vec[5] && !m1_r[msi_evt_vec[4:0]] && !eng)
			##1 !eng [*3] |-> msi_low_irq_line;
	endproperty
	a_msi_lo: assert property (p_msi_lo) else $error("low msi irq missing");
	property p_msi_hi;
		(msi_evt_valid && msi_evt_vec[5] && !m2_r[msi_evt_vec[4:0]] && !eng)
			##1 !eng [*3] |-> msi_high_irq_line;
	endproperty
	a_msi_hi: assert property (p_msi_hi) else $error("high msi irq missing");
	property p_ack;
		reg_req |=> reg_ack ##1 !reg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("register ack wrong");
	c_rel: cover property ($rose(bus_reset_n));
	c_msi: cover property ($rose(msi_high_irq_line));
	c_soft: cover property ($fell(soft_reset_n));
endmodule

/* File: tb/bridge_global_reset_irq_tb_top.sv */
// self-checking bench: apb host end joined to device end over the link
`timescale 1ns/1ps
`include "bgr_defines.svh"
module bridge_global_reset_irq_tb_top;
	import bgr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] q;
	logic e;
	int failures = 0;
	int n_checks = 0;
	always #25 pclk = ~pclk;
	bgr_link_if link_if (.pclk(pclk), .presetn(presetn));
	// short soft-reset hold keeps the run small, yet outlasts a few register accesses
	bgr_host #(.SOFT_HOLD_CYC(40)) u_bgr_host (.link(link_if), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	bgr_device u_bgr_device (.link(link_if), .bus_reset_n(), .ctl_reset_n(), .irq_line(),
		.msi_low_irq_line(), .msi_high_irq_line());
	// endpoint copy of the device end, fed from the same host signals
	logic ep_bus;
	logic ep_ctl;
	logic ep_mlo;
	logic ep_mhi;
	bgr_link_if ep_if (.pclk(pclk), .presetn(presetn));
	assign ep_if.core_user_reset_in = link_if.core_user_reset_in;
	assign ep_if.phy_ready_in = link_if.phy_ready_in;
	assign ep_if.link_up_in = link_if.link_up_in;
	assign ep_if.power_state_active = link_if.power_state_active;
	assign ep_if.soft_reset_n = link_if.soft_reset_n;
	assign ep_if.sys_rst_n = link_if.sys_rst_n;
	assign ep_if.msi_evt_valid = link_if.msi_evt_valid;
	assign ep_if.msi_evt_vec = link_if.msi_evt_vec;
	assign ep_if.intx_evt_valid = link_if.intx_evt_valid;
	assign ep_if.intx_evt_assert = link_if.intx_evt_assert;
	assign ep_if.intx_evt_line = link_if.intx_evt_line;
	assign ep_if.gen_evt_valid = link_if.gen_evt_valid;
	assign ep_if.gen_evt_bit = link_if.gen_evt_bit;
	assign ep_if.reg_req = link_if.reg_req;
	assign ep_if.reg_wr = link_if.reg_wr;
	assign ep_if.reg_idx = link_if.reg_idx;
	assign ep_if.reg_wdata = link_if.reg_wdata;
	bgr_device #(.ROOT_PORT(1'b0)) u_bgr_device_ep (.link(ep_if), .bus_reset_n(ep_bus),
		.ctl_reset_n(ep_ctl), .irq_line(), .msi_low_irq_line(ep_mlo),
		.msi_high_irq_line(ep_mhi));
	bgr_asserts u_bgr_asserts (.pclk(pclk), .presetn(presetn),
		.core_user_reset_in(link_if.core_user_reset_in), .phy_ready_in(link_if.phy_ready_in),
		.soft_reset_n(link_if.soft_reset_n), .sys_rst_n(link_if.sys_rst_n),
		.msi_evt_valid(link_if.msi_evt_valid), .msi_evt_vec(link_if.msi_evt_vec),
		.intx_evt_valid(link_if.intx_evt_valid), .intx_evt_assert(link_if.intx_evt_assert),
		.intx_evt_line(link_if.intx_evt_line), .gen_evt_valid(link_if.gen_evt_valid),
		.gen_evt_bit(link_if.gen_evt_bit), .reg_req(link_if.reg_req), .reg_wr(link_if.reg_wr),
		.reg_idx(link_if.reg_idx), .reg_wdata(link_if.reg_wdata), .reg_ack(link_if.reg_ack),
		.bus_reset_n(link_if.bus_reset_n), .ctl_reset_n(link_if.ctl_reset_n),
		.irq_line(link_if.irq_line), .msi_low_irq_line(link_if.msi_low_irq_line),
		.msi_high_irq_line(link_if.msi_high_irq_line));
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (failures == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	// pins are {bus reset, ctl reset, irq, low msi, high msi}
	task automatic pins(input logic [4:0] exp);
		repeat (4) @(negedge pclk);
		chk("pins", {27'h0, exp}, {27'h0, link_if.bus_reset_n, link_if.ctl_reset_n,
			link_if.irq_line, link_if.msi_low_irq_line, link_if.msi_high_irq_line});
	endtask
	// endpoint pins are {bus reset, ctl reset, low msi, high msi}
	task automatic ep_pins(input logic [3:0] exp);
		chk("endpoint pins", {28'h0, exp}, {28'h0, ep_bus, ep_ctl, ep_mlo, ep_mhi});
	endtask
	// pready is read right after the edge, before the slave's own update at that edge;
	// only the watchdog ends a wait that never completes
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		apb(1'b0, a, 32'h0, q, e);
		chk("read data", exp, q);
		chk("read error", {31'h0, ee}, {31'h0, e});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`BGR_HOFF_CTRL, 32'h01, 1'b0);
		pins(5'b00000);
		rd(12'h020, 32'h0, 1'b1);
		rd(12'h11c, 32'h0, 1'b1);
		wr(`BGR_HOFF_CTRL, 32'h13);
		pins(5'b00000);
		ep_pins(4'b0000);
		wr(`BGR_HOFF_CTRL, 32'h0b);
		pins(5'b11000);
		ep_pins(4'b0000);
		rd(12'h118, 32'h07, 1'b0);
		wr(`BGR_HOFF_CTRL, 32'h0f);
		pins(5'b00000);
		wr(`BGR_HOFF_CTRL, 32'h2b);
		pins(5'b11000);
		ep_pins(4'b1100);
		wr(`BGR_HOFF_GEN_EVT, 32'h05);
		pins(5'b11100);
		rd(12'h100, 32'h20, 1'b0);
		wr(12'h104, 32'h20);
		pins(5'b11000);
		wr(12'h104, 32'h0);
		pins(5'b11100);
		wr(12'h100, 32'h20);
		pins(5'b11000);
		wr(`BGR_HOFF_INTX_EVT, 32'h06);
		pins(5'b11100);
		rd(12'h108, 32'h04, 1'b0);
		wr(`BGR_HOFF_INTX_EVT, 32'h02);
		pins(5'b11000);
		wr(`BGR_HOFF_MSI_EVT, 32'h03);
		pins(5'b11010);
		ep_pins(4'b1100);
		rd(12'h110, 32'h08, 1'b0);
		wr(12'h110, 32'h08);
		pins(5'b11000);
		wr(`BGR_HOFF_MSI_EVT, 32'h28);
		pins(5'b11001);
		ep_pins(4'b1100);
		rd(12'h114, 32'h100, 1'b0);
		wr(12'h10c, 32'h100);
		pins(5'b11000);
		wr(12'h10c, 32'h0);
		pins(5'b11001);
		// soft reset: engines cleared, link level inputs untouched
		wr(`BGR_HOFF_CTRL, 32'h2a);
		pins(5'b00000);
		ep_pins(4'b0000);
		rd(`BGR_HOFF_STATUS, 32'h40, 1'b0);
		// setting the run bit early must not cut the hold short
		wr(`BGR_HOFF_CTRL, 32'h2b);
		pins(5'b00000);
		repeat (40) @(posedge pclk);
		pins(5'b11000);
		rd(12'h114, 32'h0, 1'b0);
		end_of_test;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		failures++;
		end_of_test;
	end
endmodule
